// >>> src/ledblk_pkg.sv
`default_nettype none
package ledblk_pkg;

   // ************************************************************
   // Clocking and blink time base
   // ************************************************************
   localparam int CLK_HZ      = 20_000_000;
   localparam int RGB_RATE_HZ = 20_000;
   localparam int TICK_CYCLES = CLK_HZ / RGB_RATE_HZ;
   localparam int DIV_W       = 11;
   localparam int PERMILLE_FULL = 1000;
   // Blink periods in milliseconds, indexed by the cycle time code.
   localparam int BLINK_MS [8] = '{100, 250, 500, 1000,
                                   2000, 3000, 4000, 5000};
   // On and off shares in tenths of a percent, indexed by the code.
   localparam int SHARE_PM [16] = '{0, 10, 25, 50, 75, 100, 150, 200,
                                    300, 400, 500, 600, 700, 800, 900,
                                    1000};

   // ************************************************************
   // Bus addresses and register map
   // ************************************************************
   localparam logic [6:0] DEV_ADDR_LOW  = 7'h54;
   localparam logic [6:0] DEV_ADDR_HIGH = 7'h55;
   localparam logic [7:0] BLINK_OFS [3] = '{8'h01, 8'h03, 8'h05};
   localparam logic [7:0] CYCLE_OFS [3] = '{8'h02, 8'h04, 8'h06};
   localparam logic [7:0] CTRL_OFS      = 8'h11;
   localparam int ON_LSB          = 4;
   localparam int OFF_LSB         = 0;
   localparam int CYC_EN_BIT      = 3;
   localparam int CYC_TIME_LSB    = 0;
   localparam int BLINK_START_BIT = 3;
   localparam logic [7:0] BLINK_RST = 8'h00;
   localparam logic [3:0] CYCLE_RST = 4'h0;
   localparam logic       CTRL_RST  = 1'b0;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   typedef logic [17:0] ledblk_ticks_t;
   typedef logic [2:0]  ledblk_rgb_t;

   typedef struct packed {
      logic [3:0] on_time;
      logic [3:0] off_time;
      logic [2:0] cycle_time;
   } ledblk_cfg_s;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_REG, ST_ACK_REG,
      ST_WDATA, ST_ACK_W, ST_RDATA, ST_RACK
   } ledblk_i2c_e;

   // Ticks of the 20 kHz base per tenth of a percent of the period.
   function automatic ledblk_ticks_t blink_unit(input logic [2:0] t);
      blink_unit = ledblk_ticks_t'(BLINK_MS[t] * (RGB_RATE_HZ / 1000)
                                   / PERMILLE_FULL);
   endfunction

   function automatic ledblk_ticks_t share_pm(input logic [3:0] c);
      share_pm = ledblk_ticks_t'(SHARE_PM[c]);
   endfunction

endpackage
`default_nettype wire

// >>> src/ledblk_blink_chan.sv
`default_nettype none
module ledblk_blink_chan (
   input  wire logic               ref_clk,
   input  wire logic               resetn,
   input  wire logic               tick,
   input  wire logic               restart,
   input  wire logic               run,
   input  wire ledblk_pkg::ledblk_cfg_s cfg,
   output logic                    led
);
   import ledblk_pkg::*;

   typedef struct packed {
      ledblk_ticks_t cnt;
      logic          led;
   } ledblk_chan_s;

   ledblk_chan_s  s_r;
   ledblk_chan_s  s_nxt;
   ledblk_ticks_t unit;
   ledblk_ticks_t period;
   ledblk_ticks_t off_end;
   ledblk_ticks_t on_end;
   ledblk_ticks_t on_raw;

   // ************************************************************
   // Window of the on interval within the period
   // ************************************************************
   // The off share always comes first; the on share is cut at 100 %.
   always_comb begin
      unit    = blink_unit(cfg.cycle_time);
      period  = ledblk_ticks_t'(unit * ledblk_ticks_t'(PERMILLE_FULL));
      off_end = ledblk_ticks_t'(unit * share_pm(cfg.off_time));
      on_raw  = ledblk_ticks_t'(off_end + unit * share_pm(cfg.on_time));
      on_end  = (on_raw > period) ? period : on_raw;
   end

   // Counter restarts at the off interval on each start and holds there while not running, else runs.
   always_comb begin
      s_nxt = s_r;
      if (restart || !run) begin
         s_nxt.cnt = '0;
         s_nxt.led = 1'b0;
      end else begin
         if (tick) begin
            s_nxt.cnt = (s_r.cnt == period - 18'h00001) ? '0
                                                       : s_r.cnt + 18'h00001;
         end
         s_nxt.led = (s_r.cnt >= off_end) && (s_r.cnt < on_end);
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign led = s_r.led;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   chk_restart_clears: assert property (
      restart |=> (s_r.cnt == '0) && !s_r.led)
      else $error("blink counter not cleared on restart");

   chk_on_window: assert property (
      s_r.led |-> ($past(s_r.cnt) >= $past(off_end))
                  && ($past(s_r.cnt) < $past(on_end)))
      else $error("led on outside its on interval");

   chk_period_wrap: assert property (
      (tick && run && !restart && s_r.cnt == period - 18'h00001)
      |=> s_r.cnt == '0)
      else $error("blink counter missed the period end");

   // The wrap above needs a full period, so steady counting is guarded
   // on its own where short runs can reach it.
   chk_count_step: assert property (
      (tick && run && !restart && s_r.cnt != period - 18'h00001)
      |=> s_r.cnt == $past(s_r.cnt) + 18'h00001)
      else $error("blink counter skipped a tick");

endmodule
`default_nettype wire

// >>> src/ledblk_i2c_port.sv
// Function
// - Three-bit code picks blink period.
// - Control bit three starts blinking.
// - Outputs switch on 20 kHz tick.
// - SDA change while SCL high aborts.
// - Detect start and stop conditions.
// - Bus busy from start until stop.
// - Repeated start acts as start.
// - Bytes are eight bits, MSB first.
// - Receiver pulls SDA low on ninth pulse.
// - Address byte carries seven bits plus direction.
// - Address 54H or 55H by select pin.
// - Write: register byte, then data byte.
// - Write commits at final acknowledge rise.
// - Pointer auto-increments per data byte.
// - Cycle enable lets output follow blinking.
// - Start bit launches enabled outputs together.
// - Off first, then on, cut at 100%.
// - Four-bit share codes, nonlinear steps.
`default_nettype none
module ledblk_i2c_port (
   input  wire logic              ref_clk,
   input  wire logic              resetn,
   input  wire logic              addr_sel,
   input  wire logic              scl_i,
   input  wire logic              sda_i,
   output logic                   sda_o,
   output logic                   sda_oe,
   output logic                   bus_busy,
   output ledblk_pkg::ledblk_rgb_t led_o
);
   import ledblk_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      ledblk_i2c_e      st;
      logic             scl_q;
      logic             sda_q;
      logic [7:0]       sh;
      logic [3:0]       bitcnt;
      logic             rw;
      logic             acked;
      logic [7:0]       ptr;
      logic             oe;
      logic             sda_lvl;
      logic             busy;
      logic [2:0][7:0]  blink;
      logic [2:0][3:0]  cyc;
      logic             ctrl_start;
      logic             start_pls;
      logic [DIV_W-1:0] div;
      logic             tick;
      ledblk_rgb_t      led;
   } ledblk_top_s;

   ledblk_top_s  s_r;
   ledblk_top_s  s_nxt;
   ledblk_rgb_t  led_ch;
   ledblk_cfg_s  cfg [3];
   logic         start_det;
   logic         stop_det;
   logic         scl_rise;
   logic         scl_fall;
   logic [6:0]   my_addr;

   // Register read decode, shared by the first and later read bytes.
   function automatic logic [7:0] reg_read(input ledblk_top_s s,
                                           input logic [7:0]  a);
      reg_read = 8'h00;
      for (int i = 0; i < 3; i++) begin
         if (a == BLINK_OFS[i]) begin
            reg_read = s.blink[i];
         end else if (a == CYCLE_OFS[i]) begin
            reg_read = {4'h0, s.cyc[i]};
         end
      end
      if (a == CTRL_OFS) begin
         reg_read = 8'h00;
         reg_read[BLINK_START_BIT] = s.ctrl_start;
      end
   endfunction

   // ************************************************************
   // Bus conditions
   // ************************************************************
   // Pins are taken as synchronous, so one stage of history is enough
   // to see edges; a glitch on SCL would still count as an edge.
   assign start_det = s_r.scl_q & scl_i & s_r.sda_q & ~sda_i;
   assign stop_det  = s_r.scl_q & scl_i & ~s_r.sda_q & sda_i;
   assign scl_rise  = ~s_r.scl_q & scl_i;
   assign scl_fall  = s_r.scl_q & ~scl_i;
   assign my_addr   = addr_sel ? DEV_ADDR_HIGH : DEV_ADDR_LOW;

   // ************************************************************
   // Next state
   // ************************************************************
   // One process holds the bus engine, the register file and the
   // 20 kHz divider, so every output stays a plain flip-flop.
   always_comb begin
      s_nxt = s_r;
      s_nxt.scl_q     = scl_i;
      s_nxt.sda_q     = sda_i;
      s_nxt.start_pls = 1'b0;
      s_nxt.tick      = 1'b0;
      s_nxt.sda_lvl   = 1'b0;

      // Divider from the internal clock sets the output switch rate.
      if (s_r.div == DIV_W'(TICK_CYCLES - 1)) begin
         s_nxt.div  = '0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.div = s_r.div + 1'b1;
      end
      if (s_r.tick) begin
         s_nxt.led = led_ch;
      end

      // Any SDA edge while SCL is high ends the byte in progress.
      if (start_det) begin
         s_nxt.st     = ST_ADDR;
         s_nxt.bitcnt = 4'h0;
         s_nxt.oe     = 1'b0;
         s_nxt.busy   = 1'b1;
      end else if (stop_det) begin
         s_nxt.st   = ST_IDLE;
         s_nxt.oe   = 1'b0;
         s_nxt.busy = 1'b0;
      end else begin
         case (s_r.st)
            ST_ADDR, ST_REG, ST_WDATA: begin
               if (scl_rise) begin
                  s_nxt.sh     = {s_r.sh[6:0], sda_i};
                  s_nxt.bitcnt = s_r.bitcnt + 4'h1;
               end else if (scl_fall && s_r.bitcnt == BYTE_BITS) begin
                  s_nxt.bitcnt = 4'h0;
                  if (s_r.st == ST_ADDR) begin
                     if (s_r.sh[7:1] == my_addr) begin
                        s_nxt.rw = s_r.sh[0];
                        s_nxt.oe = 1'b1;
                        s_nxt.st = ST_ACK_ADDR;
                     end else begin
                        // Stay silent until the next start.
                        s_nxt.st = ST_IDLE;
                     end
                  end else if (s_r.st == ST_REG) begin
                     s_nxt.ptr = s_r.sh;
                     s_nxt.oe  = 1'b1;
                     s_nxt.st  = ST_ACK_REG;
                  end else begin
                     s_nxt.oe = 1'b1;
                     s_nxt.st = ST_ACK_W;
                  end
               end
            end
            ST_ACK_ADDR: begin
               if (scl_fall) begin
                  s_nxt.oe = 1'b0;
                  if (s_r.rw) begin
                     s_nxt.sh     = reg_read(s_r, s_r.ptr);
                     s_nxt.oe     = ~s_nxt.sh[7];
                     s_nxt.ptr    = s_r.ptr + 8'h01;
                     s_nxt.bitcnt = 4'h0;
                     s_nxt.st     = ST_RDATA;
                  end else begin
                     s_nxt.st = ST_REG;
                  end
               end
            end
            ST_ACK_REG: begin
               if (scl_fall) begin
                  s_nxt.oe = 1'b0;
                  s_nxt.st = ST_WDATA;
               end
            end
            ST_ACK_W: begin
               // The value lands on the SCL rise inside our acknowledge.
               if (scl_rise) begin
                  for (int i = 0; i < 3; i++) begin
                     if (s_r.ptr == BLINK_OFS[i]) begin
                        s_nxt.blink[i] = s_r.sh;
                     end else if (s_r.ptr == CYCLE_OFS[i]) begin
                        s_nxt.cyc[i] = s_r.sh[3:0];
                     end
                  end
                  if (s_r.ptr == CTRL_OFS) begin
                     s_nxt.ctrl_start = s_r.sh[BLINK_START_BIT];
                     s_nxt.start_pls  = s_r.sh[BLINK_START_BIT];
                  end
                  s_nxt.ptr = s_r.ptr + 8'h01;
               end else if (scl_fall) begin
                  s_nxt.oe = 1'b0;
                  s_nxt.st = ST_WDATA;
               end
            end
            ST_RDATA: begin
               if (scl_rise) begin
                  s_nxt.bitcnt = s_r.bitcnt + 4'h1;
               end else if (scl_fall) begin
                  if (s_r.bitcnt == BYTE_BITS) begin
                     s_nxt.oe     = 1'b0;
                     s_nxt.bitcnt = 4'h0;
                     s_nxt.st     = ST_RACK;
                  end else begin
                     s_nxt.sh = {s_r.sh[6:0], 1'b0};
                     s_nxt.oe = ~s_r.sh[6];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  s_nxt.acked = ~sda_i;
               end else if (scl_fall) begin
                  if (s_r.acked) begin
                     s_nxt.sh     = reg_read(s_r, s_r.ptr);
                     s_nxt.oe     = ~s_nxt.sh[7];
                     s_nxt.ptr    = s_r.ptr + 8'h01;
                     s_nxt.bitcnt = 4'h0;
                     s_nxt.st     = ST_RDATA;
                  end else begin
                     s_nxt.st = ST_IDLE;
                  end
               end
            end
            default: begin
               s_nxt.st = ST_IDLE;
            end
         endcase
      end
   end

   // Register the whole state.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s_r            <= '0;
         s_r.st         <= ST_IDLE;
         s_r.scl_q      <= 1'b1;
         s_r.sda_q      <= 1'b1;
         s_r.blink      <= {3{BLINK_RST}};
         s_r.cyc        <= {3{CYCLE_RST}};
         s_r.ctrl_start <= CTRL_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ************************************************************
   // Blink channels
   // ************************************************************
   // All channels share one restart pulse, so enabled outputs begin
   // their off interval on the same clock edge.
   for (genvar i = 0; i < 3; i++) begin : g_chan
      assign cfg[i] = '{on_time:    s_r.blink[i][ON_LSB +: 4],
                        off_time:   s_r.blink[i][OFF_LSB +: 4],
                        cycle_time: s_r.cyc[i][CYC_TIME_LSB +: 3]};
      ledblk_blink_chan u_chan (
         .ref_clk (ref_clk),
         .resetn  (resetn),
         .tick    (s_r.tick),
         .restart (s_r.start_pls),
         .run     (s_r.ctrl_start & s_r.cyc[i][CYC_EN_BIT]),
         .cfg     (cfg[i]),
         .led     (led_ch[i])
      );
   end

   assign sda_o    = s_r.sda_lvl;
   assign sda_oe   = s_r.oe;
   assign bus_busy = s_r.busy;
   assign led_o    = s_r.led;

   // ************************************************************
   // Checks
   // ************************************************************
   logic [DIV_W-1:0] since_tick;

   // Helper: cycles since the last rate tick, counted independently.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         since_tick <= '0;
      end else begin
         since_tick <= s_r.tick ? DIV_W'(1) : since_tick + 1'b1;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   sequence s_addr_done;
      s_r.st == ST_ADDR && scl_fall && !start_det && !stop_det
         && s_r.bitcnt == BYTE_BITS;
   endsequence

   sequence s_write_commit;
      s_r.st == ST_ACK_W && scl_rise && !start_det && !stop_det;
   endsequence

   chk_tick_rate: assert property (
      s_r.tick |-> since_tick == DIV_W'(TICK_CYCLES))
      else $error("rate tick spacing is wrong");

   chk_start_busy: assert property (
      start_det |=> s_r.busy && s_r.st == ST_ADDR && s_r.bitcnt == 4'h0)
      else $error("start not taken as start");

   chk_stop_free: assert property (
      stop_det |=> !s_r.busy && s_r.st == ST_IDLE && !sda_oe)
      else $error("stop did not free the bus");

   chk_abort_release: assert property (
      (s_r.busy && (start_det || stop_det)) |=> !sda_oe)
      else $error("sda still driven after abort");

   chk_addr_ack: assert property (
      (s_addr_done and (s_r.sh[7:1] == my_addr)) |=> sda_oe
         && s_r.st == ST_ACK_ADDR)
      else $error("own address not acknowledged");

   chk_addr_ignore: assert property (
      (s_addr_done and (s_r.sh[7:1] != my_addr)) |=>
         (!sda_oe throughout (##[0:8] start_det)) or (!sda_oe [*8]))
      else $error("foreign address drove sda");

   chk_write_commit: assert property (
      (s_write_commit and (s_r.ptr == CYCLE_OFS[0])) |=>
         s_r.cyc[0] == $past(s_r.sh[3:0]) && s_r.ptr == $past(s_r.ptr) + 1)
      else $error("write not committed at acknowledge");

   chk_start_pulse: assert property (
      (s_write_commit and (s_r.ptr == CTRL_OFS)
         and s_r.sh[BLINK_START_BIT]) |=> s_r.start_pls ##1 !s_r.start_pls)
      else $error("blink start not launched");

   chk_read_drive: assert property (
      (s_r.st == ST_ACK_ADDR && s_r.rw && scl_fall && !stop_det
         && !start_det) |=> s_r.st == ST_RDATA && sda_oe == ~s_r.sh[7])
      else $error("first read bit not driven msb first");

endmodule
`default_nettype wire

// >>> dv/ledblk_bus_master.sv
`default_nettype none
module ledblk_bus_master (
   input  wire logic ref_clk,
   input  wire logic sda_line,
   output var  logic scl_o,
   output var  logic sda_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // Clocks per bus phase; the port needs at least three.
   localparam int HALF = 4;

   // ************************************************************
   // Line phases
   // ************************************************************
   // Both lines start released, so the pull-up holds them high.
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   // Change the lines just after an edge and hold them for a phase.
   task automatic phase(input logic c, input logic d);
      @(posedge ref_clk);
      scl_o <= c;
      sda_o <= d;
      repeat (HALF - 1) @(posedge ref_clk);
   endtask

   // Data falls while the clock is high, from a released line.
   task automatic start_cond();
      phase(1'b0, 1'b1);
      phase(1'b1, 1'b1);
      phase(1'b1, 1'b0);
      phase(1'b0, 1'b0);
   endtask

   // Data rises while the clock is high.
   task automatic stop_cond();
      phase(1'b0, 1'b0);
      phase(1'b1, 1'b0);
      phase(1'b1, 1'b1);
   endtask

   // The wire is read mid-clock so a late edge cannot race the sample.
   task automatic bit_slot(input logic d, output logic q);
      phase(1'b0, d);
      phase(1'b1, d);
      @(negedge ref_clk);
      q = sda_line;
   endtask

   // ************************************************************
   // Byte transfers
   // ************************************************************
   // Eight bits high first, then the line is released for the ack.
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic q;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(b[i], q);
      end
      bit_slot(1'b1, q);
      ack = ~q;
   endtask

   // The master acks every byte but the last one of a read.
   task automatic get_byte(input logic last, output logic [7:0] b);
      logic q;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, q);
         b[i] = q;
      end
      bit_slot(last, q);
   endtask
endmodule
`default_nettype wire

// >>> dv/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ledblk_pkg::*;

   // Half a blink off share at the shortest period, in clocks.
   localparam int OFF_T = BLINK_MS[0] * (RGB_RATE_HZ / 1000) * SHARE_PM[1]
                          / PERMILLE_FULL;
   localparam int Q     = OFF_T * TICK_CYCLES / 2;
   localparam int LIMIT = 75000;

   logic        ref_clk;
   logic        resetn;
   logic        addr_sel;
   logic        scl;
   logic        sda_m;
   wire  logic  sda_line;
   logic        sda_o;
   logic        sda_oe;
   logic        bus_busy;
   ledblk_rgb_t led_o;
   logic [7:0]  r0;
   logic [7:0]  r1;
   logic        a0;
   logic        a1;
   logic        q;
   int          err_count;
   int          cmp_count;
   int          cyc;

   // The line is low whenever either party pulls it down.
   assign sda_line = sda_m & (~sda_oe | sda_o);

   ledblk_i2c_port uut (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .addr_sel (addr_sel),
      .scl_i    (scl),
      .sda_i    (sda_line),
      .sda_o    (sda_o),
      .sda_oe   (sda_oe),
      .bus_busy (bus_busy),
      .led_o    (led_o)
   );

   ledblk_bus_master m (
      .ref_clk  (ref_clk),
      .sda_line (sda_line),
      .scl_o    (scl),
      .sda_o    (sda_m)
   );

   // ************************************************************
   // Clock, time limit and report
   // ************************************************************
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // A hung handshake would otherwise stall the run forever.
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err_count++;
         summarize();
      end
   end

   task automatic summarize();
      if (err_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("unexpected %s exp %h got %h", nm, e, g);
         err_count++;
      end
   endtask

   // ************************************************************
   // Register access
   // ************************************************************
   // Burst write; ok says whether the device should ack each byte.
   task automatic wr(input logic [6:0] da, input logic [7:0] ra,
                     input logic [7:0] d [4], input int n,
                     input logic ok);
      logic       a;
      logic [7:0] acks;
      acks = 8'h00;
      m.start_cond();
      m.put_byte({da, 1'b0}, a);
      acks = {acks[6:0], a};
      m.put_byte(ra, a);
      acks = {acks[6:0], a};
      for (int i = 0; i < n; i++) begin
         m.put_byte(d[i], a);
         acks = {acks[6:0], a};
      end
      m.stop_cond();
      chk("write acks", ok ? 8'((1 << (n + 2)) - 1) : 8'h00, acks);
   endtask

   // Pointer set by a write phase, then two bytes read back.
   task automatic rd(input logic [6:0] da, input logic [7:0] ra,
                     output logic [7:0] d0, output logic [7:0] d1);
      logic a;
      logic b;
      logic c;
      m.start_cond();
      m.put_byte({da, 1'b0}, a);
      m.put_byte(ra, b);
      m.start_cond();
      m.put_byte({da, 1'b1}, c);
      m.get_byte(1'b0, d0);
      m.get_byte(1'b1, d1);
      m.stop_cond();
      chk("read acks", 8'h07, {5'h00, a, b, c});
   endtask

   task automatic led_after(input int n, input ledblk_rgb_t e);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("leds", {5'h00, e}, {5'h00, led_o});
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   initial begin
      resetn    = 1'b0;
      addr_sel  = 1'b0;
      err_count = 0;
      cmp_count = 0;
      cyc       = 0;
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("idle pins", 8'h00, {3'h0, sda_oe, bus_busy, led_o});
      rd(DEV_ADDR_LOW, CYCLE_OFS[0], r0, r1);
      chk("cycle reset", 8'h00, r0);
      // Burst over a blink and a cycle register; busy mid-frame.
      m.start_cond();
      m.put_byte({DEV_ADDR_LOW, 1'b0}, a0);
      chk("busy", 8'h01, {7'h00, bus_busy});
      m.stop_cond();
      @(negedge ref_clk);
      chk("free", 8'h00, {7'h00, bus_busy});
      // The burst stays on neighbouring registers with no gap between.
      wr(DEV_ADDR_LOW, 8'h01, '{8'h11, 8'h08, 8'h00, 8'h00}, 2,
         1'b1);
      rd(DEV_ADDR_LOW, 8'h01, r0, r1);
      chk("red blink", 8'h11, r0);
      chk("red cycle", 8'h08, r1);
      wr(DEV_ADDR_LOW, 8'h06, '{8'hF8, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
      wr(DEV_ADDR_LOW, 8'h20, '{8'hFF, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
      rd(DEV_ADDR_LOW, 8'h06, r0, r1);
      chk("cycle field", 8'h08, r0);
      rd(DEV_ADDR_LOW, 8'h20, r0, r1);
      chk("unmapped", 8'h00, r0);
      // Foreign address is ignored, selected address follows the pin.
      wr(DEV_ADDR_HIGH, 8'h04, '{8'h0F, 8'h00, 8'h00, 8'h00}, 1,
         1'b0);
      @(posedge ref_clk);
      addr_sel <= 1'b1;
      wr(DEV_ADDR_HIGH, 8'h04, '{8'h0B, 8'h00, 8'h00, 8'h00}, 1,
         1'b1);
      rd(DEV_ADDR_HIGH, 8'h04, r0, r1);
      chk("green cycle", 8'h0B, r0);
      wr(DEV_ADDR_LOW, 8'h04, '{8'h0F, 8'h00, 8'h00, 8'h00}, 1,
         1'b0);
      @(posedge ref_clk);
      addr_sel <= 1'b0;
      // A stop inside a data byte drops the write.
      m.start_cond();
      m.put_byte({DEV_ADDR_LOW, 1'b0}, a0);
      m.put_byte(8'h04, a1);
      chk("abort acks", 8'h03, {6'h00, a0, a1});
      repeat (3) m.bit_slot(1'b1, q);
      m.stop_cond();
      @(negedge ref_clk);
      chk("busy after abort", 8'h00, {7'h00, bus_busy});
      rd(DEV_ADDR_LOW, 8'h04, r0, r1);
      chk("aborted write", 8'h0B, r0);
      // Green stays dark with its cycle enable off.
      wr(DEV_ADDR_LOW, 8'h03, '{8'h11, 8'h00, 8'h10, 8'h08}, 4, 1'b1);
      wr(DEV_ADDR_LOW, CTRL_OFS, '{8'h08, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
      rd(DEV_ADDR_LOW, CTRL_OFS, r0, r1);
      chk("control", 8'h08, r0);
      led_after(Q, 3'b100);
      led_after(2 * Q, 3'b001);
      led_after(2 * Q, 3'b000);
      wr(DEV_ADDR_LOW, CTRL_OFS, '{8'h08, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
      led_after(Q, 3'b100);
      wr(DEV_ADDR_LOW, CTRL_OFS, '{8'h00, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
      led_after(3 * TICK_CYCLES, 3'b000);
      summarize();
   end
endmodule
`default_nettype wire
